// ### adp_pkg.sv
// Package with register map, mode codes and reset values for the address/data port group.
package adp_pkg;
    localparam logic [15:0] ADP_LOW_DIR_ADDR = 16'hffb0;
    localparam logic [15:0] ADP_HIGH_DIR_ADDR = 16'hffb1;
    localparam logic [15:0] ADP_LOW_DATA_ADDR = 16'hffb2;
    localparam logic [15:0] ADP_HIGH_DATA_ADDR = 16'hffb3;
    localparam logic [15:0] ADP_BUS_DIR_ADDR = 16'hffb4;
    localparam logic [15:0] ADP_BUS_DATA_ADDR = 16'hffb6;
    localparam logic [7:0] ADP_REG_RESET = 8'h00;
    localparam logic [7:0] ADP_ALL_ONES = 8'hff;
    localparam logic [1:0] ADP_MODE_1 = 2'h1;
    localparam logic [1:0] ADP_MODE_2 = 2'h2;
    localparam logic [1:0] ADP_MODE_3 = 2'h3;

    typedef struct packed {
        logic [7:0] low_dir;
        logic [7:0] low_data;
        logic [7:0] high_dir;
        logic [7:0] high_data;
        logic [7:0] bus_dir;
        logic [7:0] bus_data;
        logic [7:0] rd_data;
        logic out_of_reset;
    } adp_state_type;
endpackage

// ### adp_port_group.sv
// Three 8-bit ports: low address, high address and data bus port with their registers.
// Functional notes
// - A data register read returns the latch for output pins and the live pin for input pins.
// - In modes 2 and 3 a data bit of 1 on an input pin of the address ports turns its pull-up on.
// - Pull-ups are forced off for output pins in modes 2 and 3 and for all address-port pins in mode 1.
// - In mode 1 the address ports drive address on every pin and their direction is fixed at ones.
// - In mode 2 an address-port pin is an input when its direction bit is 0 and address when 1.
// - In mode 3 the address ports are plain general-purpose ports.
// - Reset clears direction and data registers, making every pin an input with pull-up off.
// - On leaving reset in mode 1 the address-port direction registers become all ones.
// - Hardware standby puts every address-port pin in high impedance with pull-up off.
// - Software standby keeps the registers and drives address-output pins low.
// - Software standby keeps general-purpose outputs driving the data register value.
// - The high-address port carries address bits 15 to 8.
// - A direction bit of 1 makes a pin an output and 0 an input.
// - The data port is the external data bus in modes 1 and 2, and in mode 3 is GPIO or the shared RAM bus.
// - Direction registers are write-only and read back as all ones.
`timescale 1ns/1ps
`default_nettype none
module adp_port_group
    import adp_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Operating mode and power state
    input wire logic [1:0] mode,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic shared_ram_enable,
    // CPU register bus
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // External bus sources
    input wire logic [15:0] bus_address,
    input wire logic [7:0] ext_data_out,
    input wire logic ext_data_drive,
    input wire logic [7:0] ram_data_out,
    input wire logic ram_data_drive,
    // Low address port pins
    input wire logic [7:0] low_pin_in,
    output logic [7:0] low_pin_out,
    output logic [7:0] low_pin_oe_n,
    output logic [7:0] low_pullup,
    // High address port pins
    input wire logic [7:0] high_pin_in,
    output logic [7:0] high_pin_out,
    output logic [7:0] high_pin_oe_n,
    output logic [7:0] high_pullup,
    // Data port pins
    input wire logic [7:0] bus_pin_in,
    output logic [7:0] bus_pin_out,
    output logic [7:0] bus_pin_oe_n,
    output logic [7:0] bus_pullup
);
    adp_state_type state;
    adp_state_type next_state;
    logic gp_mode;
    logic [7:0] low_out_c, high_out_c, bus_out_c;
    logic [7:0] low_oe_c, high_oe_c, bus_oe_c;
    logic [7:0] low_val, high_val, bus_val;
    logic bus_gpio;

    // Mode decode; mode 1 treats every address-port direction bit as one regardless of storage.
    // The mode pins are expected to stay still while the chip runs, so no edge on
    // them is tracked; a change only takes effect through the decode below.
    assign gp_mode = (mode == ADP_MODE_3);
    assign bus_gpio = gp_mode && !shared_ram_enable;

    // Register updates and read data; the read value is registered so data outputs come from flops.
    always_comb begin
        next_state = state;
        next_state.out_of_reset = 1'b1;
        if (!state.out_of_reset && mode == ADP_MODE_1) begin
            next_state.low_dir = ADP_ALL_ONES;
            next_state.high_dir = ADP_ALL_ONES;
        end
        // Writes are ignored in hardware standby, where all pins float but reads still update the read data.
        if (reg_wr && !hw_standby) begin
            if (reg_addr == ADP_LOW_DIR_ADDR) begin
                if (mode != ADP_MODE_1) next_state.low_dir = reg_wdata;
            end else if (reg_addr == ADP_HIGH_DIR_ADDR) begin
                if (mode != ADP_MODE_1) next_state.high_dir = reg_wdata;
            end else if (reg_addr == ADP_LOW_DATA_ADDR) begin
                next_state.low_data = reg_wdata;
            end else if (reg_addr == ADP_HIGH_DATA_ADDR) begin
                next_state.high_data = reg_wdata;
            end else if (reg_addr == ADP_BUS_DIR_ADDR) begin
                next_state.bus_dir = reg_wdata;
            end else if (reg_addr == ADP_BUS_DATA_ADDR) begin
                next_state.bus_data = reg_wdata;
            end
        end
        if (reg_rd) begin
            if (reg_addr == ADP_LOW_DIR_ADDR || reg_addr == ADP_HIGH_DIR_ADDR ||
                    reg_addr == ADP_BUS_DIR_ADDR) begin
                next_state.rd_data = ADP_ALL_ONES;
            end else if (reg_addr == ADP_LOW_DATA_ADDR) begin
                next_state.rd_data = (state.low_data & state.low_dir) |
                    (low_pin_in & ~state.low_dir);
            end else if (reg_addr == ADP_HIGH_DATA_ADDR) begin
                next_state.rd_data = (state.high_data & state.high_dir) |
                    (high_pin_in & ~state.high_dir);
            end else if (reg_addr == ADP_BUS_DATA_ADDR) begin
                next_state.rd_data = (state.bus_data & state.bus_dir) |
                    (bus_pin_in & ~state.bus_dir);
            end else begin
                next_state.rd_data = ADP_REG_RESET;
            end
        end
        // Reset comes last so that it overrides any strobe seen in the same cycle.
        if (!rst_n) begin
            next_state = '0;
        end
    end

    always_ff @(posedge clock) begin
        state <= next_state;
    end

    assign reg_rdata = state.rd_data;

    // Pin drive for the two address ports. Mode 3 uses the data latch, modes 1 and 2
    // put the live bus address on output pins, and software standby pulls it low.
    always_comb begin
        if (gp_mode) begin
            low_val = state.low_data;
            high_val = state.high_data;
        end else if (sw_standby) begin
            low_val = 8'h00;
            high_val = 8'h00;
        end else begin
            low_val = bus_address[7:0];
            high_val = bus_address[15:8];
        end
        low_oe_c = state.low_dir;
        high_oe_c = state.high_dir;
        if (mode == ADP_MODE_1) begin
            low_oe_c = ADP_ALL_ONES;
            high_oe_c = ADP_ALL_ONES;
        end
        if (hw_standby || !rst_n) begin
            low_oe_c = 8'h00;
            high_oe_c = 8'h00;
        end
    end

    // The data port follows the external bus, the shared RAM bus, or its own registers.
    always_comb begin
        if (bus_gpio) begin
            bus_val = state.bus_data;
            bus_oe_c = state.bus_dir;
        end else if (gp_mode) begin
            bus_val = ram_data_out;
            bus_oe_c = (ram_data_drive && !sw_standby) ? ADP_ALL_ONES : 8'h00;
        end else begin
            bus_val = ext_data_out;
            bus_oe_c = (ext_data_drive && !sw_standby) ? ADP_ALL_ONES : 8'h00;
        end
        if (hw_standby || !rst_n) begin
            bus_oe_c = 8'h00;
        end
    end

    assign low_out_c = low_val & low_oe_c;
    assign high_out_c = high_val & high_oe_c;
    assign bus_out_c = bus_val & bus_oe_c;

    // Pin outputs. Enables are active low; pull-ups only on inputs in modes 2 and 3.
    assign low_pin_out = low_out_c;
    assign high_pin_out = high_out_c;
    assign bus_pin_out = bus_out_c;
    assign low_pin_oe_n = ~low_oe_c;
    assign high_pin_oe_n = ~high_oe_c;
    assign bus_pin_oe_n = ~bus_oe_c;
    // Reset masks the pull-ups at once, since the data latch only clears at the edge.
    assign low_pullup = (mode == ADP_MODE_1 || hw_standby || !rst_n) ? 8'h00 :
        (state.low_data & ~low_oe_c);
    assign high_pullup = (mode == ADP_MODE_1 || hw_standby || !rst_n) ? 8'h00 :
        (state.high_data & ~high_oe_c);
    assign bus_pullup = (bus_gpio && !hw_standby && rst_n) ? (state.bus_data & ~bus_oe_c) :
        8'h00;

    // Checks that tie outputs to their causes.
    sequence s_wr_low_data;
        rst_n && reg_wr && !hw_standby && reg_addr == ADP_LOW_DATA_ADDR;
    endsequence

    a_dir_read_ones: assert property (@(posedge clock) disable iff (!rst_n)
        reg_rd && reg_addr == ADP_HIGH_DIR_ADDR |=> reg_rdata == 8'hff)
        else $error("direction read not all ones");
    a_low_read_mix: assert property (@(posedge clock) disable iff (!rst_n)
        reg_rd && reg_addr == ADP_LOW_DATA_ADDR |=> reg_rdata ==
        (($past(state.low_data) & $past(state.low_dir)) | ($past(low_pin_in) & ~$past(state.low_dir))))
        else $error("low data read wrong");
    a_mode1_all_out: assert property (@(posedge clock) disable iff (!rst_n)
        mode == ADP_MODE_1 && !hw_standby |-> low_pin_oe_n == 8'h00 && high_pin_oe_n == 8'h00)
        else $error("mode 1 pins not driven");
    a_mode1_no_pull: assert property (@(posedge clock) disable iff (!rst_n)
        mode == ADP_MODE_1 |-> low_pullup == 8'h00 && high_pullup == 8'h00)
        else $error("mode 1 pull-up on");
    a_hws_float: assert property (@(posedge clock) disable iff (!rst_n)
        hw_standby |-> high_pin_oe_n == 8'hff && high_pullup == 8'h00)
        else $error("hardware standby pin not floating");
    a_sws_addr_low: assert property (@(posedge clock) disable iff (!rst_n)
        sw_standby && mode == ADP_MODE_2 |-> (high_pin_out & ~high_pin_oe_n) == 8'h00)
        else $error("address pin not low in standby");
    a_high_addr: assert property (@(posedge clock) disable iff (!rst_n)
        mode == ADP_MODE_1 && !sw_standby && !hw_standby |-> high_pin_out == bus_address[15:8])
        else $error("high address wrong");
    a_pull_follow: assert property (@(posedge clock) disable iff (!rst_n)
        s_wr_low_data ##1 (mode == ADP_MODE_3 && !hw_standby) |->
        low_pullup == ($past(reg_wdata) & state.low_dir ^ $past(reg_wdata)))
        else $error("pull-up does not follow data write");
    a_gpio_out: assert property (@(posedge clock) disable iff (!rst_n)
        mode == ADP_MODE_3 && !hw_standby |-> low_pin_out == (state.low_data & state.low_dir))
        else $error("general output wrong");

    // Reset and mode 1 start-up. The stored direction bits are hidden behind the
    // all-ones read, so these checks watch the stored copies directly.
    sequence s_mode1_release;
        $rose(rst_n) && mode == ADP_MODE_1;
    endsequence

    sequence s_wr_low_dir;
        rst_n && reg_wr && reg_addr == ADP_LOW_DIR_ADDR;
    endsequence

    sequence s_rd_bus_data;
        rst_n && reg_rd && reg_addr == ADP_BUS_DATA_ADDR;
    endsequence

    a_reset_clear: assert property (@(posedge clock)
        !rst_n |=> state.low_dir == 8'h00 && state.low_data == 8'h00 &&
        state.bus_dir == 8'h00 && state.high_data == 8'h00)
        else $error("reset did not clear registers");
    a_reset_float: assert property (@(posedge clock)
        !rst_n |-> low_pin_oe_n == 8'hff && low_pullup == 8'h00 && bus_pullup == 8'h00)
        else $error("pin driven or pulled up in reset");
    a_mode1_dir_set: assert property (@(posedge clock) disable iff (!rst_n)
        s_mode1_release |=> state.low_dir == 8'hff && state.high_dir == 8'hff)
        else $error("mode 1 direction not set after reset");
    a_mode1_dir_lock: assert property (@(posedge clock) disable iff (!rst_n)
        s_wr_low_dir ##0 (mode == ADP_MODE_1 && state.low_dir == 8'hff) |=>
        state.low_dir == 8'hff)
        else $error("mode 1 direction write took effect");
    a_wr_low_data: assert property (@(posedge clock) disable iff (!rst_n)
        s_wr_low_data |=> state.low_data == $past(reg_wdata))
        else $error("low data write lost");

    // Address output in the expanded modes.
    a_low_addr: assert property (@(posedge clock) disable iff (!rst_n)
        mode == ADP_MODE_1 && !sw_standby && !hw_standby |-> low_pin_out == bus_address[7:0])
        else $error("low address wrong");
    a_mode2_dir: assert property (@(posedge clock) disable iff (!rst_n)
        mode == ADP_MODE_2 && !hw_standby |-> high_pin_oe_n == ~state.high_dir)
        else $error("mode 2 pin direction wrong");
    a_mode2_addr: assert property (@(posedge clock) disable iff (!rst_n)
        mode == ADP_MODE_2 && !sw_standby && !hw_standby |->
        high_pin_out == (bus_address[15:8] & state.high_dir))
        else $error("mode 2 address pin wrong");

    // Standby behaviour.
    a_low_hws: assert property (@(posedge clock) disable iff (!rst_n)
        hw_standby |-> low_pin_oe_n == 8'hff && low_pullup == 8'h00)
        else $error("hardware standby low pin not floating");
    a_sws_keep: assert property (@(posedge clock) disable iff (!rst_n)
        sw_standby && !reg_wr |=> $stable(state.low_dir) && $stable(state.low_data))
        else $error("software standby lost a register");
    a_sws_gp_hold: assert property (@(posedge clock) disable iff (!rst_n)
        sw_standby && mode == ADP_MODE_3 && !hw_standby |->
        high_pin_out == (state.high_data & state.high_dir))
        else $error("software standby output changed");

    // Pull-up control.
    a_mode3_pull: assert property (@(posedge clock) disable iff (!rst_n)
        mode == ADP_MODE_3 && !hw_standby |->
        high_pullup == (state.high_data & ~state.high_dir))
        else $error("pull-up does not follow data bit");
    a_out_no_pull: assert property (@(posedge clock) disable iff (!rst_n)
        !hw_standby |-> (low_pullup & ~low_pin_oe_n) == 8'h00 &&
        (high_pullup & ~high_pin_oe_n) == 8'h00)
        else $error("pull-up on a driven pin");

    // Data port.
    a_bus_dir_oe: assert property (@(posedge clock) disable iff (!rst_n)
        mode == ADP_MODE_3 && !shared_ram_enable && !hw_standby |->
        bus_pin_oe_n == ~state.bus_dir)
        else $error("data port direction wrong");
    a_ext_bus: assert property (@(posedge clock) disable iff (!rst_n)
        mode == ADP_MODE_2 && ext_data_drive && !sw_standby && !hw_standby |->
        bus_pin_oe_n == 8'h00 && bus_pin_out == ext_data_out)
        else $error("external data bus not driven");
    a_ram_bus: assert property (@(posedge clock) disable iff (!rst_n)
        mode == ADP_MODE_3 && shared_ram_enable && ram_data_drive && !sw_standby &&
        !hw_standby |-> bus_pin_oe_n == 8'h00 && bus_pin_out == ram_data_out)
        else $error("shared RAM bus not driven");
    a_bus_read_mix: assert property (@(posedge clock) disable iff (!rst_n)
        s_rd_bus_data |=> reg_rdata == (($past(state.bus_data) & $past(state.bus_dir)) |
        ($past(bus_pin_in) & ~$past(state.bus_dir))))
        else $error("data port read wrong");
    a_bus_dir_read: assert property (@(posedge clock) disable iff (!rst_n)
        reg_rd && reg_addr == ADP_BUS_DIR_ADDR |=> reg_rdata == 8'hff)
        else $error("data port direction read not all ones");
    a_rdata_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule
`default_nettype wire

// ### adp_pin_model.sv
// Pin-side model that resolves each port wire from the block and an outside driver.
`timescale 1ns/1ps
`default_nettype none
module adp_pin_model (
    // Block side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] oe_n,
    input wire logic [7:0] pull_en,
    // Outside side
    input wire logic [7:0] ext_val,
    input wire logic ext_drive,
    output logic [7:0] pin_in
);
    // A floating pin with no pull-up reads inverted, so a stale level cannot pass.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!oe_n[i]) pin_in[i] = pin_out[i];
            else if (ext_drive) pin_in[i] = ext_val[i];
            else pin_in[i] = pull_en[i] | ~ext_val[i];
        end
    end
endmodule
`default_nettype wire

// ### adp_port_group_tb.sv
// Self-checking testbench for the address/data port group.
`timescale 1ns/1ps
`default_nettype none
module adp_port_group_tb
    import adp_pkg::*;
;
    logic clock = 0, rst_n = 0, hw_standby = 0, sw_standby = 0, shared_ram_enable = 0;
    logic reg_wr = 0, reg_rd = 0, ext_data_drive = 0, ram_data_drive = 0, ext_drive = 1;
    logic [1:0] mode = ADP_MODE_3;
    logic [15:0] reg_addr = '0, bus_address = 16'h1234;
    logic [7:0] reg_wdata = '0, ext_data_out = 8'h5a, ram_data_out = 8'hc3, reg_rdata;
    logic [7:0] low_pin_in, low_pin_out, low_pin_oe_n, low_pullup;
    logic [7:0] high_pin_in, high_pin_out, high_pin_oe_n, high_pullup;
    logic [7:0] bus_pin_in, bus_pin_out, bus_pin_oe_n, bus_pullup;
    int fail_count = 0, num_checks = 0;
    adp_port_group dut_u (.clock, .rst_n, .mode, .hw_standby, .sw_standby, .shared_ram_enable,
        .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .bus_address, .ext_data_out,
        .ext_data_drive, .ram_data_out, .ram_data_drive, .low_pin_in, .low_pin_out,
        .low_pin_oe_n, .low_pullup, .high_pin_in, .high_pin_out, .high_pin_oe_n, .high_pullup,
        .bus_pin_in, .bus_pin_out, .bus_pin_oe_n, .bus_pullup);
    // Outside world drives 3c on released pins, or lets them float when ext_drive is low.
    adp_pin_model low_u (.pin_out(low_pin_out), .oe_n(low_pin_oe_n), .pull_en(low_pullup),
        .ext_val(8'h3c), .ext_drive(ext_drive), .pin_in(low_pin_in));
    adp_pin_model high_u (.pin_out(high_pin_out), .oe_n(high_pin_oe_n), .pull_en(high_pullup),
        .ext_val(8'h3c), .ext_drive(ext_drive), .pin_in(high_pin_in));
    adp_pin_model bus_u (.pin_out(bus_pin_out), .oe_n(bus_pin_oe_n), .pull_en(bus_pullup),
        .ext_val(8'h3c), .ext_drive(ext_drive), .pin_in(bus_pin_in));
    initial begin
        forever #4 clock = ~clock;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Strobes drop at the next edge, so back-to-back calls leave one idle cycle.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
    endtask
    // Lets one edge take the inputs just driven, then waits for outputs to settle.
    task automatic settle();
        @(posedge clock);
        #1;
    endtask
    task automatic restart(input logic [1:0] m);
        @(posedge clock);
        mode <= m;
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic t_reset();
        restart(ADP_MODE_3);
        chk("low_pullup", 8'h00, low_pullup);
        rdchk(ADP_LOW_DATA_ADDR, 8'h3c);
        rdchk(ADP_LOW_DIR_ADDR, 8'hff);
        rdchk(ADP_BUS_DIR_ADDR, 8'hff);
        rdchk(16'hffb5, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_gpio();
        wr(ADP_LOW_DIR_ADDR, 8'h0f);
        wr(ADP_LOW_DATA_ADDR, 8'ha5);
        chk("low_pin_oe_n", 8'hf0, low_pin_oe_n);
        chk("low_pin_out", 8'h05, low_pin_out & 8'h0f);
        chk("low_pullup", 8'ha0, low_pullup);
        rdchk(ADP_LOW_DATA_ADDR, 8'h35);
        // Floating inputs read their pull-up where on and the inverse of 3c elsewhere.
        @(posedge clock);
        ext_drive <= 1'b0;
        settle();
        rdchk(ADP_LOW_DATA_ADDR, 8'he5);
        wr(ADP_BUS_DATA_ADDR, 8'h81);
        chk("bus_pullup", 8'h81, bus_pullup);
        @(posedge clock);
        ext_drive <= 1'b1;
        sw_standby <= 1'b1;
        settle();
        chk("low_pin_out", 8'h05, low_pin_out & 8'h0f);
        @(posedge clock);
        sw_standby <= 1'b0;
        hw_standby <= 1'b1;
        settle();
        chk("low_pin_oe_n", 8'hff, low_pin_oe_n);
        chk("low_pullup", 8'h00, low_pullup);
        @(posedge clock);
        hw_standby <= 1'b0;
        shared_ram_enable <= 1'b1;
        ram_data_drive <= 1'b1;
        settle();
        chk("bus_pin_out", 8'hc3, bus_pin_out & ~bus_pin_oe_n);
        chk("bus_pullup", 8'h00, bus_pullup);
        @(posedge clock);
        shared_ram_enable <= 1'b0;
        ram_data_drive <= 1'b0;
        $display("single-chip test done");
    endtask
    task automatic t_mode2();
        restart(ADP_MODE_2);
        wr(ADP_HIGH_DIR_ADDR, 8'hf0);
        wr(ADP_HIGH_DATA_ADDR, 8'h0f);
        chk("high_pin_oe_n", 8'h0f, high_pin_oe_n);
        chk("high_pin_out", 8'h10, high_pin_out & 8'hf0);
        chk("high_pullup", 8'h0f, high_pullup);
        @(posedge clock);
        sw_standby <= 1'b1;
        settle();
        chk("high_pin_out", 8'h00, high_pin_out & ~high_pin_oe_n);
        @(posedge clock);
        sw_standby <= 1'b0;
        ext_data_drive <= 1'b1;
        settle();
        chk("bus_pin_out", 8'h5a, bus_pin_out & ~bus_pin_oe_n);
        @(posedge clock);
        ext_data_drive <= 1'b0;
        $display("mode 2 test done");
    endtask
    task automatic t_mode1();
        restart(ADP_MODE_1);
        wr(ADP_LOW_DIR_ADDR, 8'h00);
        wr(ADP_HIGH_DIR_ADDR, 8'h00);
        chk("low_pin_oe_n", 8'h00, low_pin_oe_n);
        chk("high_pin_oe_n", 8'h00, high_pin_oe_n);
        chk("low_pin_out", 8'h34, low_pin_out);
        chk("high_pullup", 8'h00, high_pullup);
        // With direction all ones the read returns the latch, not the driven address.
        rdchk(ADP_LOW_DATA_ADDR, 8'h00);
        rdchk(ADP_HIGH_DATA_ADDR, 8'h00);
        $display("mode 1 test done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Whole sequence needs about 60 cycles; the watchdog allows far more.
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        complete_run();
    end
    initial begin
        t_reset();
        t_gpio();
        t_mode2();
        t_mode1();
        complete_run();
    end
endmodule
`default_nettype wire
